// *** sarc_pkg.sv ***
// Package and successive-approximation step logic for the converter control
`timescale 1ns/100ps

package sarc_pkg;

    localparam int CLK_MHZ = 40;
    localparam int RES_BITS = 10;

    // Register offsets
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CHSEL = 8'h01;
    localparam logic [7:0] A_PINCFG = 8'h02;
    localparam logic [7:0] A_WORD = 8'h03;
    localparam logic [7:0] A_HIGH = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h05;
    localparam logic [7:0] A_CLEAR = 8'h06;
    localparam logic [7:0] A_ENABLE = 8'h07;

    // Field positions
    localparam int RUN_BIT = 7;
    localparam int PWR_BIT = 0;
    localparam int FSEL_LSB = 1;
    localparam int DONE_BIT = 0;

    // Reset values
    localparam logic [9:0] RES_RESET = 10'h000;
    localparam logic [4:0] FSEL_RESET = 5'h00;
    localparam logic [1:0] CH_RESET = 2'h0;
    localparam logic [3:0] PCFG_RESET = 4'h0;

    // Successive-approximation start values and last step index
    localparam logic [9:0] SAR_TRIAL_MSB = 10'h200;
    localparam logic [3:0] IDX_MSB = 4'h9;
    localparam logic [3:0] IDX_LSB = 4'h0;

    // Timing
    localparam int SAMPLE_TIME_NS = 500;
    localparam int STEP_TIME_NS = 100;
    localparam int SAMPLE_CYC_INT = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP_CYC_INT = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYC_INT - 1);
    localparam logic [4:0] STEP_LAST = 5'(STEP_CYC_INT - 1);

    typedef enum logic [1:0] {
        S_IDLE,
        S_SAMPLE,
        S_CONV
    } sarc_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sarc_bus_req_type;

    typedef struct packed {
        logic [9:0] code;
        logic [1:0] ch;
        logic sample;
        logic pwr;
        logic [3:0] pin_analog;
    } sarc_ana_out_type;

endpackage

// Next successive-approximation value for one comparison step
module sarc_sar_step
    import sarc_pkg::*;
(
    input wire logic [9:0] cur_i,
    input wire logic [3:0] idx_i,
    input wire logic cmp_i,
    output logic [9:0] nxt_o
);

    for (genvar b = 0; b < RES_BITS; b++) begin : g_bit
        assign nxt_o[b] = (4'(b) > idx_i) ? cur_i[b] :
                          (4'(b) == idx_i) ? cmp_i :
                          (4'(b + 1) == idx_i) ? 1'b1 : 1'b0;
    end

endmodule

// *** sarc_top.sv ***
// Control logic of the 10-bit successive-approximation converter
//
// Behaviour
// - Converter stops all conversion while the standby input is high.
// - Result read colliding with a result store returns the old value.
// - Mode, channel or pin write at completion discards result and interrupt.
// - Writing channel select leaves the done flag untouched.
// - Completion just before a channel write still stores and flags.
// - Configuration writes may spoil results; read results before writing.
// - Results are ten bits from one of four channels.
// - Run bit starts continuous conversions, each storing and raising interrupt.
// - Channel write aborts conversion and restarts it while running.
// - Clearing run bit stops at once and keeps the last result.
// - Word result is left-justified times 64; byte holds upper eight bits.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps

module sarc_top
    import sarc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire sarc_bus_req_type bus_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    input wire logic stop_i,
    input wire logic comp_i,
    output sarc_ana_out_type ana_o
);

    typedef struct packed {
        sarc_state_type state;
        logic [4:0] cnt;
        logic [3:0] idx;
        logic [9:0] sar;
        logic [9:0] result;
        logic run;
        logic pwr;
        logic [4:0] fsel;
        logic [1:0] ch;
        logic [3:0] pcfg;
        logic flag;
        logic ien;
        logic [15:0] rdata;
        logic irq;
        logic [1:0] csync;
        logic done;
        logic smp;
    } sarc_regs_type;

    sarc_regs_type st_q;
    sarc_regs_type st_d;
    logic [9:0] sar_nxt;
    logic wr_mode;
    logic wr_ch;
    logic wr_cfg;
    logic conv_end;
    logic store_now;
    logic clr_flag;

    sarc_sar_step u_step (
        .cur_i(st_q.sar),
        .idx_i(st_q.idx),
        .cmp_i(st_q.csync[1]),
        .nxt_o(sar_nxt)
    );

    assign wr_mode = bus_i.wr && (bus_i.addr == A_MODE);
    assign wr_ch = bus_i.wr && (bus_i.addr == A_CHSEL);
    assign wr_cfg = wr_mode || wr_ch || (bus_i.wr && (bus_i.addr == A_PINCFG));
    assign clr_flag = bus_i.wr && (bus_i.addr == A_CLEAR) && bus_i.wdata[DONE_BIT];
    assign conv_end = (st_q.state == S_CONV) && (st_q.cnt == STEP_LAST) && (st_q.idx == IDX_LSB);
    assign store_now = conv_end && !wr_cfg && !stop_i;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.rdata = 16'h0000;
        st_d.csync = {st_q.csync[0], comp_i};

        // Register writes
        if (wr_mode) begin
            st_d.run = bus_i.wdata[RUN_BIT];
            st_d.pwr = bus_i.wdata[PWR_BIT];
            st_d.fsel = bus_i.wdata[FSEL_LSB +: 5];
        end
        if (wr_ch) begin
            st_d.ch = bus_i.wdata[1:0];
        end
        if (bus_i.wr && (bus_i.addr == A_PINCFG)) begin
            st_d.pcfg = bus_i.wdata[3:0];
        end
        if (bus_i.wr && (bus_i.addr == A_ENABLE)) begin
            st_d.ien = bus_i.wdata[DONE_BIT];
        end

        // Sequencer
        case (st_q.state)
            S_IDLE: begin
                st_d.cnt = 5'h00;
            end
            S_SAMPLE: begin
                st_d.cnt = st_q.cnt + 5'h01;
                if (st_q.cnt == SAMPLE_LAST) begin
                    st_d.state = S_CONV;
                    st_d.cnt = 5'h00;
                    st_d.idx = IDX_MSB;
                    st_d.sar = SAR_TRIAL_MSB;
                end
            end
            S_CONV: begin
                st_d.cnt = st_q.cnt + 5'h01;
                if (st_q.cnt == STEP_LAST) begin
                    st_d.sar = sar_nxt;
                    st_d.cnt = 5'h00;
                    st_d.idx = st_q.idx - 4'h1;
                    if (st_q.idx == IDX_LSB) begin
                        st_d.state = S_SAMPLE;
                        st_d.idx = IDX_MSB;
                        if (store_now) begin
                            st_d.result = sar_nxt;
                            st_d.done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_d.state = S_IDLE;
                st_d.cnt = 5'h00;
            end
        endcase

        // run bit set from idle starts sampling
        if (st_d.run && (st_q.state == S_IDLE)) begin
            st_d.state = S_SAMPLE;
            st_d.cnt = 5'h00;
        end
        if (wr_ch && st_d.run) begin
            st_d.state = S_SAMPLE;
            st_d.cnt = 5'h00;
            st_d.idx = IDX_MSB;
        end
        // run bit cleared stops at once
        if (!st_d.run) begin
            st_d.state = S_IDLE;
            st_d.cnt = 5'h00;
        end
        if (stop_i) begin
            st_d.state = S_IDLE;
            st_d.cnt = 5'h00;
        end
        // results kept as they are on configuration writes

        // set wins over clear; channel writes leave flag
        st_d.flag = (st_q.flag && !clr_flag) || st_d.done;
        st_d.irq = st_d.flag && st_d.ien;
        st_d.smp = (st_d.state == S_SAMPLE);

        // read served from the value held before the store
        if (bus_i.rd) begin
            case (bus_i.addr)
                A_MODE: st_d.rdata = {8'h00, st_q.run, 1'b0, st_q.fsel, st_q.pwr};
                A_CHSEL: st_d.rdata = {14'h0000, st_q.ch};
                A_PINCFG: st_d.rdata = {12'h000, st_q.pcfg};
                A_WORD: st_d.rdata = {st_q.result, 6'h00};
                A_HIGH: st_d.rdata = {8'h00, st_q.result[9:2]};
                A_STATUS: st_d.rdata = {15'h0000, st_q.flag};
                A_ENABLE: st_d.rdata = {15'h0000, st_q.ien};
                default: st_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '{state: S_IDLE, cnt: 5'h00, idx: IDX_MSB, sar: RES_RESET, result: RES_RESET,
                      run: 1'b0, pwr: 1'b0, fsel: FSEL_RESET, ch: CH_RESET, pcfg: PCFG_RESET,
                      flag: 1'b0, ien: 1'b0, rdata: 16'h0000, irq: 1'b0, csync: 2'h0,
                      done: 1'b0, smp: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o = st_q.rdata;
    assign irq_o = st_q.irq;
    assign ana_o = '{code: st_q.sar, ch: st_q.ch, sample: st_q.smp, pwr: st_q.pwr, pin_analog: st_q.pcfg};

    // Checks
    sequence s_conv_entry;
        (st_q.state == S_SAMPLE) ##1 (st_q.state == S_CONV);
    endsequence

    sequence s_word_read;
        bus_i.rd && (bus_i.addr == A_WORD);
    endsequence

    property p_stop_idle;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        stop_i |=> (st_q.state == S_IDLE) && !ana_o.sample;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("activity during standby");

    property p_read_old;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (s_word_read and store_now) |=> (rdata_o == {$past(st_q.result), 6'h00}) && st_q.done;
    endproperty
    a_read_old: assert property (p_read_old) else $error("read did not return old result");

    property p_cfg_wins;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (conv_end && wr_cfg) |=> !st_q.done && (st_q.result == $past(st_q.result));
    endproperty
    a_cfg_wins: assert property (p_cfg_wins) else $error("result stored despite config write");

    property p_ch_keeps_flag;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_ch && st_q.flag) |=> st_q.flag;
    endproperty
    a_ch_keeps_flag: assert property (p_ch_keeps_flag) else $error("channel write cleared flag");

    property p_done_flag;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        st_q.done |-> st_q.flag ##1 (st_q.flag || $past(clr_flag));
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag not set with result");

    property p_ch_restart;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_ch && st_q.run && !stop_i && !wr_mode) |=> (st_q.state == S_SAMPLE) && (st_q.cnt == 5'h00);
    endproperty
    a_ch_restart: assert property (p_ch_restart) else $error("channel write did not restart");

    property p_run_stop;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_mode && !bus_i.wdata[RUN_BIT]) |=> (st_q.state == S_IDLE) && !st_q.done
            && $stable(st_q.result);
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("clearing run did not stop");

    property p_word_scaled;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_word_read |=> (rdata_o[5:0] == 6'h00) && (rdata_o[15:6] == $past(st_q.result));
    endproperty
    a_word_scaled: assert property (p_word_scaled) else $error("word result not scaled");

    property p_msb_first;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_conv_entry |-> (ana_o.code == SAR_TRIAL_MSB) && (st_q.idx == IDX_MSB);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("conversion not started at MSB");

    property p_continuous;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        st_q.done && st_q.run && !stop_i && !bus_i.wr |-> (st_q.state == S_SAMPLE) ##1 (st_q.cnt == 5'h01);
    endproperty
    a_continuous: assert property (p_continuous) else $error("next conversion not started");

    property p_irq_level;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        st_q.done && st_q.ien |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt missing on result");

    sequence s_step_end;
        (st_q.state == S_CONV) && (st_q.cnt == STEP_LAST) && (st_q.idx != IDX_LSB);
    endsequence

    property p_step_down;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_step_end ##1 (st_q.state == S_CONV) |-> (st_q.idx == $past(st_q.idx) - 4'h1);
    endproperty
    a_step_down: assert property (p_step_down) else $error("step did not move to next bit");

    sequence s_store_then_ch;
        st_q.done ##1 wr_ch;
    endsequence

    property p_prechange;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_store_then_ch |=> st_q.flag && $stable(st_q.result);
    endproperty
    a_prechange: assert property (p_prechange) else $error("prior channel result lost");

    property p_high_byte;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (bus_i.rd && (bus_i.addr == A_HIGH)) |=> (rdata_o == {8'h00, $past(st_q.result[9:2])});
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte not upper result bits");

    property p_flag_hold;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (st_q.flag && !clr_flag) |=> st_q.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped without clear");

endmodule

// *** sarc_ana_model.sv ***
// Analog side model: per-channel input levels and the comparator
`timescale 1ns/100ps

module sarc_ana_model
    import sarc_pkg::*;
(
    input wire sarc_ana_out_type ana_i,
    input wire logic [39:0] level_i,
    output logic comp_o
);
    logic [9:0] lvl;
    assign lvl = level_i[ana_i.ch * 10 +: 10];
    assign comp_o = ana_i.pwr & (lvl >= ana_i.code);
endmodule

// *** sarc_top_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/100ps

module sarc_top_tb
    import sarc_pkg::*;
;
    logic ref_clk_i;
    logic nrst_i;
    sarc_bus_req_type bus;
    logic [15:0] rdata;
    logic irq;
    logic stop;
    logic comp;
    sarc_ana_out_type ana;
    logic [39:0] levels;
    logic [39:0] tmp;
    logic [11:0] rows [5];
    logic [15:0] old;
    int failures;
    int num_checks;
    int cyc;

    sarc_top i_sarc_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
        .irq_o(irq), .stop_i(stop), .comp_i(comp), .ana_o(ana));
    sarc_ana_model i_sarc_ana_model (.ana_i(ana), .level_i(levels), .comp_o(comp));

    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        bus <= '0;
        @(posedge ref_clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string msg);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk_i);
        bus <= '0;
        @(posedge ref_clk_i);
        chk(rdata, exp, msg);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk({15'h0000, irq}, 16'h0001, "irq after conversion");
    endtask

    initial begin
        ref_clk_i = 1'b0;
        nrst_i = 1'b0;
        bus = '0;
        stop = 1'b0;
        levels = '0;
        rows = '{{2'h0, 10'h3FF}, {2'h1, 10'h000}, {2'h2, 10'h2AA}, {2'h3, 10'h155}, {2'h0, 10'h201}};
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        rchk(A_WORD, 16'h0000, "word reset");
        rchk(A_HIGH, 16'h0000, "high reset");
        rchk(A_STATUS, 16'h0000, "status reset");
        rchk(A_MODE, 16'h0000, "mode reset");
        rchk(A_CLEAR, 16'h0000, "clear reads zero");
        rchk(8'h1F, 16'h0000, "unmapped read");
        wr(A_ENABLE, 16'h0001);
        wr(A_MODE, 16'h0001);
        repeat (40) @(posedge ref_clk_i);
        wr(A_MODE, 16'h0081);
        foreach (rows[i]) begin
            tmp = {4{~rows[i][9:0]}};
            tmp[rows[i][11:10] * 10 +: 10] = rows[i][9:0];
            levels <= tmp;
            wr(A_CHSEL, {14'h0000, rows[i][11:10]});
            wr(A_CLEAR, 16'h0001);
            wait_irq();
            rchk(A_WORD, {rows[i][9:0], 6'h00}, "word result");
            rchk(A_HIGH, {8'h00, rows[i][9:2]}, "high result");
            rchk(A_STATUS, 16'h0001, "done flag");
        end
        wr(A_CLEAR, 16'h0001);
        wait_irq();
        wr(A_CHSEL, 16'h0001);
        rchk(A_STATUS, 16'h0001, "flag kept on channel write");
        rchk(A_WORD, 16'h8040, "previous channel result kept");
        wr(A_ENABLE, 16'h0000);
        chk({15'h0000, irq}, 16'h0000, "masked irq");
        wr(A_CLEAR, 16'h0001);
        rchk(A_STATUS, 16'h0000, "flag cleared");
        wr(A_ENABLE, 16'h0001);
        wr(A_MODE, 16'h0001);
        repeat (100) @(posedge ref_clk_i);
        rchk(A_STATUS, 16'h0000, "no flag after run cleared");
        rchk(A_WORD, 16'h8040, "result kept after stop");
        chk({15'h0000, ana.sample}, 16'h0000, "no sampling when stopped");
        stop <= 1'b1;
        wr(A_CLEAR, 16'h0001);
        wr(A_MODE, 16'h0081);
        repeat (100) @(posedge ref_clk_i);
        rchk(A_STATUS, 16'h0000, "no flag in standby");
        stop <= 1'b0;
        wait_irq();
        rchk(A_WORD, 16'h7F80, "result after standby");
        old = 16'h7F80;
        for (int k = 0; k < 4; k++) begin
            wr(A_MODE, 16'h0001);
            wr(A_CLEAR, 16'h0001);
            levels <= {10'h000, 10'h000, 10'h300 + 10'(k), 10'h000};
            wr(A_MODE, 16'h0081);
            repeat (58) @(posedge ref_clk_i);
            if (k == 0) begin
                rchk(A_WORD, old, "read at store gets old");
                old = {10'h300, 6'h00};
                rchk(A_WORD, old, "new result after read");
            end else begin
                wr(k == 1 ? A_MODE : (k == 2 ? A_CHSEL : A_PINCFG), k == 1 ? 16'h0081 : (k == 2 ? 16'h0001 : 16'h000F));
                rchk(A_STATUS, 16'h0000, "store discarded");
                chk({15'h0000, irq}, 16'h0000, "no irq on discard");
                rchk(A_WORD, old, "result unchanged");
            end
        end
        rchk(A_CHSEL, 16'h0001, "channel readback");
        rchk(A_PINCFG, 16'h000F, "pin config readback");
        chk({12'h000, ana.pin_analog}, 16'h000F, "pin config output");
        rchk(A_ENABLE, 16'h0001, "enable readback");
        wr(A_WORD, 16'hFFFF);
        rchk(A_WORD, old, "result write ignored");
        wr(A_MODE, 16'h003F);
        rchk(A_MODE, 16'h003F, "mode readback");
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk({15'h0000, irq}, 16'h0000, "irq in reset");
        chk(rdata, 16'h0000, "rdata in reset");
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        rchk(A_WORD, 16'h0000, "word after reset");
        rchk(A_HIGH, 16'h0000, "high after reset");
        rchk(A_STATUS, 16'h0000, "status after reset");
        rchk(A_MODE, 16'h0000, "mode after reset");
        close_out();
    end
endmodule
